// file: design/sca_client_avail.v
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "sca_defines.vh"

module sca_client_avail #(
   parameter INIT_CYC = `SCA_INIT_TIME_US * `SCA_CLK_MHZ,
   parameter AVAIL_CYC = `SCA_AVAIL_TIME_US * `SCA_CLK_MHZ,
   parameter CNT_W = 17,
   parameter [31:0] DEV_INFO = 32'h00000031
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_clk_en,
   // Pins from outside this clock domain
   input wire i_power_good_in,
   input wire i_pkg_reset_n,
   input wire [1:0] i_socket_position_strap,
   input wire i_power_on_config_straps,
   input wire i_cores_out_of_reset,
   input wire i_fatal_error,
   input wire [1:0] i_sleep_state,
   // Command port from the link decoder
   input wire i_cmd_valid,
   input wire [3:0] i_cmd_class,
   input wire i_cmd_core_deep,
   input wire i_cmd_res_low_power,
   input wire i_temp_valid,
   input wire [15:0] i_temp_value,
   output reg o_rsp_valid,
   output reg [7:0] o_rsp_cc,
   output reg [31:0] o_rsp_data,
   output reg o_rsp_forward,
   output reg o_wake_c2,
   output reg o_link_drive_en,
   output reg [7:0] o_client_addr,
   output reg [1:0] o_avail_state,
   // AXI4-Lite slave
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function reg_mapped;
      input [3:0] addr;
      begin
         reg_mapped = (addr == `SCA_REG_CTRL) || (addr == `SCA_REG_FILTER) ||
                      (addr == `SCA_REG_STATUS) || (addr == `SCA_REG_TEMP);
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam SW = 9;
   wire [SW-1:0] pins_raw;
   reg [SW-1:0] pins_meta_q;
   reg [SW-1:0] pins_q;
   assign pins_raw = {i_sleep_state, i_fatal_error, i_cores_out_of_reset,
                      i_power_on_config_straps, i_socket_position_strap,
                      i_pkg_reset_n, i_power_good_in};
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         pins_meta_q <= {SW{1'b0}};
         pins_q <= {SW{1'b0}};
      end else if (i_clk_en) begin
         pins_meta_q <= pins_raw;
         pins_q <= pins_meta_q;
      end
   end
   wire pg_s = pins_q[0];
   wire pkg_rst_n_s = pins_q[1];
   wire [1:0] strap_s = pins_q[3:2];
   wire float_s = pins_q[4];
   wire cores_up_s = pins_q[5];
   wire fatal_s = pins_q[6];
   wire [1:0] sleep_s = pins_q[8:7];
   wire in_s0 = (sleep_s == 2'h0);
   wire in_s0_s1 = (sleep_s[1] == 1'b0);

   // ----------------------------------------
   // Availability state machine
   // ----------------------------------------
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] cnt_d;
   reg pg_prev_q;
   reg rst_prev_q;
   reg [7:0] addr_q;
   wire pg_rise = pg_s & ~pg_prev_q;
   // Reset value matches the synchroniser's, so no false edge follows i_rst
   wire rst_fall = rst_prev_q & ~pkg_rst_n_s;

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      if (!pg_s) begin
         state_d = `SCA_ST_OFF;
         cnt_d = {CNT_W{1'b0}};
      end else begin
         case (state_q)
            `SCA_ST_OFF: begin
               if (cnt_q == INIT_CYC[CNT_W-1:0] - 1'b1) begin
                  state_d = `SCA_ST_DNR;
                  cnt_d = {CNT_W{1'b0}};
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            `SCA_ST_DNR: begin
               if (!pkg_rst_n_s) begin
                  cnt_d = {CNT_W{1'b0}};
               end else if (cnt_q == AVAIL_CYC[CNT_W-1:0] - 1'b1) begin
                  state_d = `SCA_ST_AVX;
                  cnt_d = {CNT_W{1'b0}};
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            `SCA_ST_AVX: begin
               if (cores_up_s)
                  state_d = `SCA_ST_FULL;
            end
            default: begin
               state_d = `SCA_ST_FULL;
            end
         endcase
         // Any package reset pulls a running client back to data-not-ready
         if (state_q != `SCA_ST_OFF && !pkg_rst_n_s) begin
            state_d = `SCA_ST_DNR;
            cnt_d = {CNT_W{1'b0}};
         end
      end
   end

   // Address is kept over warm reset; only a fresh power-good edge reloads it
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q <= `SCA_ST_OFF;
         cnt_q <= {CNT_W{1'b0}};
         pg_prev_q <= 1'b0;
         rst_prev_q <= 1'b0;
         addr_q <= `SCA_ADDR_BASE;
      end else if (i_clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         pg_prev_q <= pg_s;
         rst_prev_q <= pkg_rst_n_s;
         if (pg_rise)
            addr_q <= `SCA_ADDR_BASE + {6'h00, strap_s};
      end
   end

   // ----------------------------------------
   // Software registers and temperature
   // ----------------------------------------
   reg wake_q;
   reg [7:0] filter_q;
   reg [15:0] temp_q;
   reg [3:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire warm_rst = !pkg_rst_n_s;
   wire wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire wr_ok = reg_mapped(aw_addr_q);

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         wake_q <= `SCA_CTRL_RST;
         filter_q <= `SCA_FILTER_RST;
         temp_q <= `SCA_TEMP_RST;
      end else if (i_clk_en) begin
         if (warm_rst) begin
            wake_q <= `SCA_CTRL_RST;
            temp_q <= `SCA_TEMP_RST;
         end else begin
            if (i_temp_valid && state_q[1])
               temp_q <= i_temp_value;
            if (wr_go && aw_addr_q == `SCA_REG_CTRL && w_strb_q[0])
               wake_q <= w_data_q[`SCA_CTRL_WAKE_BIT];
         end
         // Filter constant survives warm reset on purpose
         if (wr_go && aw_addr_q == `SCA_REG_FILTER && w_strb_q[0])
            filter_q <= w_data_q[7:0];
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         `SCA_REG_CTRL: rd_mux[`SCA_CTRL_WAKE_BIT] = wake_q;
         `SCA_REG_FILTER: rd_mux[7:0] = filter_q;
         `SCA_REG_STATUS: begin
            rd_mux[`SCA_STAT_STATE_LSB+1:`SCA_STAT_STATE_LSB] = state_q;
            rd_mux[`SCA_STAT_PG_BIT] = pg_s;
            rd_mux[`SCA_STAT_FATAL_BIT] = fatal_s;
            rd_mux[`SCA_STAT_FLOAT_BIT] = float_s;
            rd_mux[`SCA_STAT_ADDR_LSB+7:`SCA_STAT_ADDR_LSB] = addr_q;
         end
         `SCA_REG_TEMP: rd_mux[15:0] = temp_q;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SCA_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SCA_RESP_OKAY;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else if (i_clk_en) begin
         if (s_axi_awready && s_axi_awvalid) begin
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `SCA_RESP_OKAY : `SCA_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= reg_mapped(s_axi_araddr) ? `SCA_RESP_OKAY : `SCA_RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Command gating
   // ----------------------------------------
   // A fatal error lifts data-not-ready to the partial level for debug
   wire [1:0] eff_state = (state_q == `SCA_ST_DNR && fatal_s) ? `SCA_ST_AVX : state_q;
   wire data_not_ready_phase = (eff_state == `SCA_ST_DNR);
   reg [7:0] cc_d;
   reg [31:0] data_d;
   reg fwd_d;
   reg wake_d;

   always @* begin
      cc_d = `SCA_CC_PASS;
      data_d = 32'h00000000;
      fwd_d = 1'b0;
      wake_d = 1'b0;
      case (i_cmd_class)
         `SCA_CMD_PROBE: cc_d = `SCA_CC_PASS;
         `SCA_CMD_DEV_INFO: data_d = DEV_INFO;
         `SCA_CMD_TEMP: data_d = data_not_ready_phase ? 32'h00000000 : {16'h0000, temp_q};
         `SCA_CMD_PKG_RD, `SCA_CMD_PKG_WR: begin
            if (data_not_ready_phase)
               cc_d = `SCA_CC_NO_RES;
            else
               fwd_d = 1'b1;
         end
         `SCA_CMD_CORE_RD: begin
            if (state_q != `SCA_ST_FULL || !in_s0)
               cc_d = `SCA_CC_NO_RES;
            else if (i_cmd_core_deep)
               cc_d = `SCA_CC_LOW_PWR;
            else
               fwd_d = 1'b1;
         end
         `SCA_CMD_LCFG_RD, `SCA_CMD_LCFG_WR, `SCA_CMD_BCFG_RD: begin
            if (data_not_ready_phase)
               cc_d = `SCA_CC_NO_RES;
            else if (i_cmd_class == `SCA_CMD_BCFG_RD ? !in_s0 : !in_s0_s1)
               cc_d = `SCA_CC_NO_RES;
            else if (i_cmd_res_low_power && !wake_q)
               cc_d = `SCA_CC_LOW_PWR;
            else begin
               fwd_d = 1'b1;
               wake_d = i_cmd_res_low_power;
            end
         end
         default: cc_d = `SCA_CC_ILLEGAL;
      endcase
   end

   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_rsp_valid <= 1'b0;
         o_rsp_cc <= 8'h00;
         o_rsp_data <= 32'h00000000;
         o_rsp_forward <= 1'b0;
         o_wake_c2 <= 1'b0;
         o_link_drive_en <= 1'b0;
         o_client_addr <= `SCA_ADDR_BASE;
         o_avail_state <= `SCA_ST_OFF;
      end else if (i_clk_en) begin
         // Off or tri-stated: no answer, the wire reads as zeros
         // A warm reset drops only the answer in flight; while it is held the
         // client sits in data-not-ready and still answers probe and info
         o_link_drive_en <= pg_s && !float_s && !rst_fall;
         o_client_addr <= addr_q;
         o_avail_state <= state_q;
         o_wake_c2 <= 1'b0;
         o_rsp_valid <= 1'b0;
         o_rsp_forward <= 1'b0;
         if (i_cmd_valid && state_q != `SCA_ST_OFF && !float_s && !rst_fall) begin
            o_rsp_valid <= 1'b1;
            o_rsp_cc <= cc_d;
            o_rsp_data <= cc_d[`SCA_CC_FAIL_BIT] ? 32'h00000000 : data_d;
            o_rsp_forward <= fwd_d;
            o_wake_c2 <= wake_d;
         end
      end
   end

endmodule // sca_client_avail
`default_nettype wire

// file: pkg/sca_defines.vh
`ifndef SCA_DEFINES_VH
`define SCA_DEFINES_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SCA_CLK_MHZ 200
`define SCA_INIT_TIME_US 100
`define SCA_AVAIL_TIME_US 500
// ----------------------------------------
// Availability states
// ----------------------------------------
`define SCA_ST_OFF 2'h0
`define SCA_ST_DNR 2'h1
`define SCA_ST_AVX 2'h2
`define SCA_ST_FULL 2'h3
// ----------------------------------------
// Command classes from the link decoder
// ----------------------------------------
`define SCA_CMD_PROBE 4'h0
`define SCA_CMD_DEV_INFO 4'h1
`define SCA_CMD_TEMP 4'h2
`define SCA_CMD_PKG_RD 4'h3
`define SCA_CMD_PKG_WR 4'h4
`define SCA_CMD_CORE_RD 4'h5
`define SCA_CMD_LCFG_RD 4'h6
`define SCA_CMD_LCFG_WR 4'h7
`define SCA_CMD_BCFG_RD 4'h8
// ----------------------------------------
// Completion codes
// ----------------------------------------
`define SCA_CC_PASS 8'h40
`define SCA_CC_NO_RES 8'h81
`define SCA_CC_LOW_PWR 8'h82
`define SCA_CC_ILLEGAL 8'h90
`define SCA_CC_FAIL_BIT 7
// ----------------------------------------
// Client address
// ----------------------------------------
`define SCA_ADDR_BASE 8'h30
// ----------------------------------------
// Register map (byte offsets) and fields
// ----------------------------------------
`define SCA_REG_CTRL 4'h0
`define SCA_REG_FILTER 4'h4
`define SCA_REG_STATUS 4'h8
`define SCA_REG_TEMP 4'hC
`define SCA_CTRL_WAKE_BIT 0
`define SCA_CTRL_RST 1'h0
`define SCA_FILTER_RST 8'h00
`define SCA_STAT_STATE_LSB 0
`define SCA_STAT_PG_BIT 2
`define SCA_STAT_FATAL_BIT 3
`define SCA_STAT_FLOAT_BIT 4
`define SCA_STAT_ADDR_LSB 8
`define SCA_TEMP_RST 16'h0000
`define SCA_RESP_OKAY 2'h0
`define SCA_RESP_SLVERR 2'h2
`endif

// file: testbench/sca_client_avail_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "sca_defines.vh"
module sca_client_avail_checker #(
   parameter INIT_CYC = 8,
   parameter AVAIL_CYC = 16
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_power_good_in,
   input wire i_pkg_reset_n,
   input wire i_power_on_config_straps,
   input wire i_cmd_valid,
   input wire [3:0] i_cmd_class,
   input wire o_rsp_valid,
   input wire [7:0] o_rsp_cc,
   input wire [31:0] o_rsp_data,
   input wire o_rsp_forward,
   input wire o_wake_c2,
   input wire o_link_drive_en,
   input wire [7:0] o_client_addr,
   input wire [1:0] o_avail_state
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // Pin-high run lengths; the two-flop sync adds a small slack to each window
   logic [16:0] pg_cnt_q;
   logic [16:0] rn_cnt_q;
   always @(posedge i_sys_clk) begin
      pg_cnt_q <= i_power_good_in ? pg_cnt_q + 17'h1 : 17'h0;
      rn_cnt_q <= i_pkg_reset_n ? rn_cnt_q + 17'h1 : 17'h0;
   end
   property p_off_silent;
      // Answer and state are registered on the same edge from the same state
      o_rsp_valid |-> o_avail_state != `SCA_ST_OFF;
   endproperty
   a_off_silent: assert property (p_off_silent) else $error("answer while off");
   property p_float;
      (i_power_on_config_straps || !i_power_good_in) [*4] |=> !o_link_drive_en;
   endproperty
   a_float: assert property (p_float) else $error("link driven while floated");
   property p_init_time;
      ($past(o_avail_state) == `SCA_ST_OFF && o_avail_state == `SCA_ST_DNR)
         |-> pg_cnt_q >= INIT_CYC && pg_cnt_q <= INIT_CYC + 6;
   endproperty
   a_init_time: assert property (p_init_time) else $error("init time wrong");
   property p_avail_time;
      ($past(o_avail_state) == `SCA_ST_DNR && o_avail_state == `SCA_ST_AVX)
         |-> rn_cnt_q >= AVAIL_CYC && rn_cnt_q <= AVAIL_CYC + 6;
   endproperty
   a_avail_time: assert property (p_avail_time) else $error("avail time wrong");
   property p_temp_dnr;
      o_rsp_valid && $past(i_cmd_class) == `SCA_CMD_TEMP && o_avail_state == `SCA_ST_DNR
         |-> o_rsp_data == 32'h0;
   endproperty
   a_temp_dnr: assert property (p_temp_dnr) else $error("temp not hot");
   property p_core_gate;
      o_rsp_valid && $past(i_cmd_class) == `SCA_CMD_CORE_RD && o_avail_state != `SCA_ST_FULL
         |-> o_rsp_cc == `SCA_CC_NO_RES;
   endproperty
   a_core_gate: assert property (p_core_gate) else $error("core read early");
   property p_cc_bit;
      o_rsp_valid |-> o_rsp_cc[`SCA_CC_FAIL_BIT] == (o_rsp_cc != `SCA_CC_PASS);
   endproperty
   a_cc_bit: assert property (p_cc_bit) else $error("fail bit wrong");
   property p_fail_nodata;
      o_rsp_valid && o_rsp_cc[7] |-> o_rsp_data == 32'h0 && !o_rsp_forward;
   endproperty
   a_fail_nodata: assert property (p_fail_nodata) else $error("data on fail");
   property p_wake;
      o_wake_c2 |-> o_rsp_valid && o_rsp_forward && o_rsp_cc == `SCA_CC_PASS;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without pass");
   property p_addr_hold;
      o_avail_state != `SCA_ST_OFF && $past(o_avail_state) != `SCA_ST_OFF |-> $stable(o_client_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   property p_rsp_cause;
      o_rsp_valid |-> $past(i_cmd_valid) && o_client_addr[7:2] == 6'h0C;
   endproperty
   a_rsp_cause: assert property (p_rsp_cause) else $error("answer without command");
   c_wake: cover property (o_wake_c2);
   c_full: cover property (o_avail_state == `SCA_ST_FULL);
   c_low: cover property (o_rsp_valid && o_rsp_cc == `SCA_CC_LOW_PWR);
endmodule // sca_client_avail_checker
bind sca_client_avail sca_client_avail_checker #(.INIT_CYC(INIT_CYC), .AVAIL_CYC(AVAIL_CYC)) i_chk (.*);
`default_nettype wire

// file: testbench/sca_bmc_model.sv
`timescale 1ns/1ps
`default_nettype none
module sca_bmc_model (
   input wire logic i_sys_clk,
   output logic o_cmd_valid,
   output logic [3:0] o_cmd_class,
   output logic o_cmd_core_deep,
   output logic o_cmd_res_low_power,
   input wire logic i_rsp_valid,
   input wire logic [7:0] i_rsp_cc,
   input wire logic [31:0] i_rsp_data,
   input wire logic i_rsp_forward,
   input wire logic i_rsp_wake
);
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_class = 4'hF;
      o_cmd_core_deep = 1'b0;
      o_cmd_res_low_power = 1'b0;
   end
   // Qualifiers are inverted when idle so nothing leans on a stale value
   task send(input [3:0] c, input dp, input lp, output got, output [7:0] cc, output [31:0] d,
             output [1:0] fw);
      @(posedge i_sys_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_class <= c;
      o_cmd_core_deep <= dp;
      o_cmd_res_low_power <= lp;
      @(posedge i_sys_clk);
      o_cmd_valid <= 1'b0;
      o_cmd_class <= ~c;
      o_cmd_core_deep <= ~dp;
      o_cmd_res_low_power <= ~lp;
      @(posedge i_sys_clk);
      got = i_rsp_valid;
      cc = i_rsp_cc;
      d = i_rsp_data;
      fw = {i_rsp_wake, i_rsp_forward};
   endtask
endmodule // sca_bmc_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sca_defines.vh"
module tb_top;
   localparam logic [31:0] DINFO = 32'h00000031;
   logic i_sys_clk = 1'b0, i_rst = 1'b1, i_clk_en = 1'b1, i_power_good_in = 1'b0;
   logic i_pkg_reset_n = 1'b0, i_power_on_config_straps = 1'b0, i_cores_out_of_reset = 1'b0;
   logic i_fatal_error = 1'b0, i_temp_valid = 1'b0;
   logic [1:0] i_socket_position_strap = 2'h2, i_sleep_state = 2'h0;
   logic [15:0] i_temp_value = 16'h0000;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire logic i_cmd_valid, i_cmd_core_deep, i_cmd_res_low_power, o_rsp_valid, o_rsp_forward;
   wire logic o_wake_c2, o_link_drive_en, s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire logic s_axi_arready, s_axi_rvalid;
   wire logic [3:0] i_cmd_class;
   wire logic [7:0] o_rsp_cc, o_client_addr;
   wire logic [31:0] o_rsp_data, s_axi_rdata;
   wire logic [1:0] o_avail_state, s_axi_bresp, s_axi_rresp;
   int n_mismatch = 0, check_count = 0;
   logic got;
   logic [7:0] cc;
   logic [31:0] rd, dd;
   logic [1:0] rr;
   logic [1:0] fw;
   always #2.5 i_sys_clk = ~i_sys_clk;
   // Short counts keep the run small; the checker inherits them through bind
   sca_client_avail #(.INIT_CYC(8), .AVAIL_CYC(16), .DEV_INFO(DINFO)) i_dut (.*);
   sca_bmc_model i_bmc (.i_sys_clk(i_sys_clk), .o_cmd_valid(i_cmd_valid),
      .o_cmd_class(i_cmd_class), .o_cmd_core_deep(i_cmd_core_deep),
      .o_cmd_res_low_power(i_cmd_res_low_power), .i_rsp_valid(o_rsp_valid),
      .i_rsp_cc(o_rsp_cc), .i_rsp_data(o_rsp_data), .i_rsp_forward(o_rsp_forward),
      .i_rsp_wake(o_wake_c2));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input [31:0] seen, input [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task cmd(input [3:0] c, input dp, input lp, input ev, input [7:0] ecc);
      i_bmc.send(c, dp, lp, got, cc, dd, fw);
      chk(got, ev, "answer presence");
      if (ev) chk(cc, ecc, "completion code");
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge i_sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge i_sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      rr = s_axi_bresp;
   endtask
   task rdr(input [3:0] a);
      @(posedge i_sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge i_sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
   endtask
   task wait_st(input [1:0] s, input int lo, input int hi);
      int n;
      n = 0;
      while (o_avail_state !== s && n < hi + 2) begin
         @(posedge i_sys_clk);
         n++;
      end
      chk(n >= lo && n <= hi, 1, "state timing");
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_up;
      cmd(`SCA_CMD_PROBE, 0, 0, 0, 0);
      chk(o_link_drive_en, 0, "drive while off");
      i_power_good_in <= 1'b1;
      wait_st(`SCA_ST_DNR, 8, 14);
      i_socket_position_strap <= 2'h1;
      cmd(`SCA_CMD_PROBE, 0, 0, 1, `SCA_CC_PASS);
      cmd(`SCA_CMD_DEV_INFO, 0, 0, 1, `SCA_CC_PASS);
      chk(dd, DINFO, "revision word");
      cmd(`SCA_CMD_TEMP, 0, 0, 1, `SCA_CC_PASS);
      chk(dd, 32'h0, "hot reading");
      for (int c = 3; c <= 8; c++) cmd(c[3:0], 0, 0, 1, `SCA_CC_NO_RES);
      cmd(4'hA, 0, 0, 1, `SCA_CC_ILLEGAL);
      chk(o_client_addr, 8'h32, "strap address");
      $display("test power-up done");
   endtask
   task t_avail;
      i_pkg_reset_n <= 1'b1;
      wait_st(`SCA_ST_AVX, 16, 22);
      cmd(`SCA_CMD_PKG_RD, 0, 0, 1, `SCA_CC_PASS);
      chk(fw, 2'h1, "forwarded");
      cmd(`SCA_CMD_CORE_RD, 0, 0, 1, `SCA_CC_NO_RES);
      cmd(`SCA_CMD_LCFG_RD, 0, 1, 1, `SCA_CC_LOW_PWR);
      chk(fw, 2'h0, "held back");
      wr(`SCA_REG_CTRL, 32'h1);
      cmd(`SCA_CMD_LCFG_WR, 0, 1, 1, `SCA_CC_PASS);
      chk(fw, 2'h3, "wake to C2");
      i_sleep_state <= 2'h1;
      tick(3);
      cmd(`SCA_CMD_LCFG_RD, 0, 0, 1, `SCA_CC_PASS);
      cmd(`SCA_CMD_BCFG_RD, 0, 0, 1, `SCA_CC_NO_RES);
      i_sleep_state <= 2'h0;
      i_temp_valid <= 1'b1;
      i_temp_value <= 16'h1234;
      tick(1);
      i_temp_valid <= 1'b0;
      tick(3);
      cmd(`SCA_CMD_TEMP, 0, 0, 1, `SCA_CC_PASS);
      chk(dd, 32'h1234, "temperature");
      $display("test available done");
   endtask
   task t_full;
      i_cores_out_of_reset <= 1'b1;
      wait_st(`SCA_ST_FULL, 1, 6);
      cmd(`SCA_CMD_CORE_RD, 1, 0, 1, `SCA_CC_LOW_PWR);
      cmd(`SCA_CMD_CORE_RD, 0, 0, 1, `SCA_CC_PASS);
      cmd(`SCA_CMD_PKG_WR, 1, 1, 1, `SCA_CC_PASS);
      $display("test full done");
   endtask
   task t_warm;
      wr(`SCA_REG_FILTER, 32'h5A);
      i_pkg_reset_n <= 1'b0;
      // The probe lands on the edge where the synced reset first falls
      tick(1);
      cmd(`SCA_CMD_PROBE, 0, 0, 0, 0);
      cmd(`SCA_CMD_PROBE, 0, 0, 1, `SCA_CC_PASS);
      cmd(`SCA_CMD_LCFG_RD, 0, 0, 1, `SCA_CC_NO_RES);
      chk(o_avail_state, `SCA_ST_DNR, "warm state");
      i_pkg_reset_n <= 1'b1;
      tick(3);
      cmd(`SCA_CMD_PKG_RD, 0, 0, 1, `SCA_CC_NO_RES);
      i_fatal_error <= 1'b1;
      tick(3);
      cmd(`SCA_CMD_LCFG_RD, 0, 0, 1, `SCA_CC_PASS);
      cmd(`SCA_CMD_CORE_RD, 0, 0, 1, `SCA_CC_NO_RES);
      i_fatal_error <= 1'b0;
      rdr(`SCA_REG_FILTER);
      chk(rd, 32'h5A, "filter kept");
      rdr(`SCA_REG_CTRL);
      chk(rd, 32'h0, "wake cleared");
      rdr(`SCA_REG_TEMP);
      chk(rd, 32'h0, "temp cleared");
      chk(o_client_addr, 8'h32, "address kept");
      $display("test warm reset done");
   endtask
   task t_bus;
      rdr(`SCA_REG_STATUS);
      chk(rd[15:8], 8'h32, "status address");
      rdr(4'h2);
      chk(rr, `SCA_RESP_SLVERR, "unmapped read");
      wr(4'h2, 32'hFF);
      chk(rr, `SCA_RESP_SLVERR, "unmapped write");
      i_power_on_config_straps <= 1'b1;
      tick(4);
      chk(o_link_drive_en, 0, "floated");
      cmd(`SCA_CMD_PROBE, 0, 0, 0, 0);
      chk(o_client_addr, 8'h32, "float address");
      i_power_on_config_straps <= 1'b0;
      i_power_good_in <= 1'b0;
      tick(5);
      chk(o_avail_state, `SCA_ST_OFF, "power off");
      cmd(`SCA_CMD_PROBE, 0, 0, 0, 0);
      $display("test bus and float done");
   endtask
   // ----------------------------------------
   // Sequence and watchdog
   // ----------------------------------------
   initial begin
      tick(2);
      i_rst <= 1'b0;
      tick(1);
      t_up;
      t_avail;
      t_full;
      t_warm;
      t_bus;
      wrap_up;
   end
   initial begin
      tick(4000);
      n_mismatch++;
      $display("mismatch at %0t: timeout", $time);
      wrap_up;
   end
endmodule // tb_top
`default_nettype wire
